// ===== verif/rmc_bus_master.sv
module rmc_bus_master
   import rmc_pkg::*;
(
   input wire logic         ref_clk,
   output rmc_reg_req_t     reg_req,
   input wire rmc_reg_rsp_t reg_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req = '0;

   // one register access, answer taken once ack shows
   task automatic rw(input logic w, input logic [15:0] a, d,
                     output rmc_reg_rsp_t r);
      int n;
      @(negedge ref_clk);
      reg_req = '{stb: 1'b1, wr: w, addr: a, wdata: d};
      @(negedge ref_clk);
      reg_req.stb = 1'b0;
      reg_req.wdata = ~d;
      n = 0;
      while (reg_rsp.ack !== 1'b1 && n < 4) begin
         @(negedge ref_clk);
         n++;
      end
      r = reg_rsp;
   endtask

   // upper half at even address, then lower half, two separate accesses
   task automatic wr32(input logic [15:0] a, input logic [31:0] d);
      rmc_reg_rsp_t r;
      rw(1'b1, a, d[31:16], r);
      rw(1'b1, a + 16'h0001, d[15:0], r);
   endtask
endmodule

// ===== verif/rmc_cmd_properties.sv
module rmc_cmd_properties
   import rmc_pkg::*;
(
   input wire logic           ref_clk,
   input wire logic           sys_rst,
   input wire rmc_reg_req_t   reg_req,
   input wire rmc_reg_rsp_t   reg_rsp,
   input wire logic           load_hold_en,
   input wire logic [31:0]    driver_status,
   input wire logic [31:0]    group_address,
   input wire rmc_motor_cmd_t motor_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_ack_follows_req: assert property (reg_req.stb |=> reg_rsp.ack)
      else $error("no ack after request");
   a_ack_has_cause: assert property (reg_rsp.ack |-> $past(reg_req.stb))
      else $error("ack without request");
   a_group_upper_wr: assert property (reg_req.stb && reg_req.wr &&
      reg_req.addr == ADDR_GROUP_HIGH |=>
      group_address[31:16] == $past(reg_req.wdata))
      else $error("group upper half not written");
   a_group_lower_wr: assert property (reg_req.stb && reg_req.wr &&
      reg_req.addr == ADDR_GROUP_LOW |=>
      group_address[15:0] == $past(reg_req.wdata))
      else $error("group lower half not written");
   a_status_ro_err: assert property (reg_req.stb && reg_req.wr &&
      reg_req.addr == ADDR_REMOTE_OUTPUT_LOW |=> reg_rsp.err)
      else $error("status write not refused");
   a_status_read: assert property (reg_req.stb && !reg_req.wr &&
      reg_req.addr == ADDR_REMOTE_OUTPUT_HIGH |=>
      reg_rsp.rdata == driver_status[31:16])
      else $error("status upper half wrong");
   a_upper_in_zero: assert property (reg_req.stb && !reg_req.wr &&
      reg_req.addr == ADDR_REMOTE_INPUT_HIGH |=> reg_rsp.rdata == 16'h0000)
      else $error("upper input word not zero");
   a_brake_at_stop: assert property (motor_cmd.brake_release |->
      !motor_cmd.run) else $error("brake released while running");
   a_shaft_free_hold: assert property (motor_cmd.shaft_free |->
      !motor_cmd.run && $past(load_hold_en))
      else $error("shaft freed without holding");
endmodule

bind rmc_remote_motor_command_map rmc_cmd_properties chk_u (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req),
   .reg_rsp(reg_rsp), .load_hold_en(load_hold_en),
   .driver_status(driver_status), .group_address(group_address),
   .motor_cmd(motor_cmd));

// ===== verif/testbench.sv
module testbench;
   import rmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic             ref_clk;
   logic             sys_rst;
   rmc_reg_req_t     reg_req;
   rmc_reg_rsp_t     reg_rsp;
   rmc_reg_rsp_t     rsp;
   logic [15:0][3:0] remote_fn_sel;
   logic [5:0][3:0]  direct_fn_sel;
   logic [5:0]       direct_in;
   logic             three_wire_mode;
   logic             load_hold_en;
   logic [31:0]      driver_status;
   logic [31:0]      group_address;
   rmc_motor_cmd_t   motor_cmd;
   int               n_mismatch;
   int               n_tests;

   rmc_bus_master mst_u (.ref_clk(ref_clk), .reg_req(reg_req),
      .reg_rsp(reg_rsp));
   rmc_remote_motor_command_map dut_u (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .remote_fn_sel(remote_fn_sel), .direct_fn_sel(direct_fn_sel),
      .direct_in(direct_in), .three_wire_mode(three_wire_mode),
      .load_hold_en(load_hold_en), .driver_status(driver_status),
      .group_address(group_address), .motor_cmd(motor_cmd));

   // ***********************************************************
   // access and compare tasks
   // ***********************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [16:0] exp);
      mst_u.rw(1'b0, a, 16'h0000, rsp);
      chk({14'h0000, rsp.ack, rsp.err, rsp.rdata}, {14'h0000, 1'b1, exp});
   endtask
   task automatic wr(input logic [15:0] a, d, input logic e);
      mst_u.rw(1'b1, a, d, rsp);
      chk({30'h0000_0000, rsp.ack, rsp.err}, {30'h0000_0000, 1'b1, e});
   endtask
   // expected {run,reverse,decel,brake,shaft,panel,op[2:0]}
   task automatic cmd(input logic m, input logic [15:0] w,
                      input logic [8:0] exp);
      three_wire_mode = m;
      wr(ADDR_REMOTE_INPUT_LOW, w, 1'b0);
      repeat (3) @(negedge ref_clk);
      chk({23'h00_0000, motor_cmd}, {23'h00_0000, exp});
   endtask
   task automatic summarize;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      remote_fn_sel = REMOTE_MAP_DEFAULT;
      direct_fn_sel = '0;
      direct_in = 6'h00;
      three_wire_mode = 1'b0;
      load_hold_en = 1'b1;
      driver_status = 32'hC3A5_5A3C;
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      chk(group_address, GROUP_RST);
      rd(ADDR_GROUP_LOW, 17'h0_0000);
      mst_u.wr32(ADDR_GROUP_HIGH, 32'h1234_ABCD);
      chk(group_address, 32'h1234_ABCD);
      rd(ADDR_GROUP_HIGH, 17'h0_1234);
      rd(ADDR_GROUP_LOW, 17'h0_ABCD);
      rd(ADDR_REMOTE_OUTPUT_HIGH, 17'h0_C3A5);
      wr(ADDR_REMOTE_OUTPUT_LOW, 16'h0000, 1'b1);
      rd(ADDR_REMOTE_OUTPUT_LOW, 17'h0_5A3C);
      wr(ADDR_REMOTE_INPUT_HIGH, 16'hFFFF, 1'b0);
      rd(ADDR_REMOTE_INPUT_HIGH, 17'h0_0000);
      rd(16'h0040, 17'h1_0000);
      cmd(1'b0, 16'h0009, 9'h109);
      cmd(1'b0, 16'h0017, 9'h18F);
      cmd(1'b0, 16'h00A0, 9'h068);
      cmd(1'b0, 16'h0089, 9'h109);
      cmd(1'b0, 16'h0018, 9'h008);
      rd(ADDR_REMOTE_INPUT_LOW, 17'h0_0018);
      cmd(1'b1, 16'h0038, 9'h1C8);
      cmd(1'b1, 16'h0090, 9'h068);
      cmd(1'b1, 16'h0008, 9'h008);
      remote_fn_sel[8] = FN_HOLD_FREE;
      remote_fn_sel[9] = FN_PANEL;
      remote_fn_sel[10] = FN_OP0;
      cmd(1'b0, 16'h0500, 9'h011);
      direct_fn_sel[0] = FN_PANEL;
      direct_in = 6'h01;
      cmd(1'b0, 16'h0200, 9'h008);
      direct_in = 6'h00;
      cmd(1'b0, 16'h0200, 9'h000);
      summarize();
   end
endmodule

// ===== verilog/rmc_pkg.sv
package rmc_pkg;

   // ***********************************************************
   // register addresses (16-bit register numbers)
   // ***********************************************************
   localparam logic [15:0] ADDR_GROUP_HIGH        = 16'h0030;
   localparam logic [15:0] ADDR_GROUP_LOW         = 16'h0031;
   localparam logic [15:0] ADDR_REMOTE_INPUT_HIGH = 16'h007C;
   localparam logic [15:0] ADDR_REMOTE_INPUT_LOW  = 16'h007D;
   localparam logic [15:0] ADDR_REMOTE_OUTPUT_HIGH = 16'h007E;
   localparam logic [15:0] ADDR_REMOTE_OUTPUT_LOW = 16'h007F;

   // ***********************************************************
   // reset values and widths
   // ***********************************************************
   localparam logic [31:0] GROUP_RST        = 32'h0000_0000;
   localparam logic [15:0] REMOTE_INPUT_RST = 16'h0000;
   localparam logic [15:0] RESERVED_READ    = 16'h0000;
   localparam int          REMOTE_TERMS     = 16;
   localparam int          DIRECT_TERMS     = 6;

   // ***********************************************************
   // input function codes for terminal assignment
   // ***********************************************************
   localparam logic [3:0] FN_UNUSED     = 4'h0;
   localparam logic [3:0] FN_FWD_GATE   = 4'h1; // forward_run / motion_gate
   localparam logic [3:0] FN_REV_QHALT  = 4'h2; // backward_run / quick_halt
   localparam logic [3:0] FN_STYLE_DIR  = 4'h3; // halt_style / direction
   localparam logic [3:0] FN_BRAKE_FREE = 4'h4; // brake_release_on_stop
   localparam logic [3:0] FN_HOLD_FREE  = 4'h5; // hold_release
   localparam logic [3:0] FN_PANEL      = 4'h6; // panel_unlock
   localparam logic [3:0] FN_OP0        = 4'h7; // op_select_bit0
   localparam logic [3:0] FN_OP1        = 4'h8; // op_select_bit1
   localparam logic [3:0] FN_OP2        = 4'h9; // op_select_bit2
   localparam int         FN_COUNT      = 10;

   // default remote terminal map, terminal 0 in the low nibble
   localparam logic [15:0][3:0] REMOTE_MAP_DEFAULT = {
      {8{FN_UNUSED}}, FN_BRAKE_FREE, FN_UNUSED, FN_STYLE_DIR,
      FN_REV_QHALT, FN_FWD_GATE, FN_OP2, FN_OP1, FN_OP0};

   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic        stb;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } rmc_reg_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } rmc_reg_rsp_t;

   typedef struct packed {
      logic       run;
      logic       reverse;
      logic       decel_stop;
      logic       brake_release;
      logic       shaft_free;
      logic       panel_unlock;
      logic [2:0] op_data_no;
   } rmc_motor_cmd_t;

   // {assigned, active} for one function over a terminal set
   function automatic logic [1:0] rmc_scan(
      input logic [3:0]        code,
      input logic [15:0][3:0]  sel,
      input logic [15:0]       val);
      logic asg;
      logic act;
      asg = 1'b0;
      act = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (sel[i] == code) begin
            asg = 1'b1;
            act = act | val[i];
         end
      end
      return {asg, act};
   endfunction

endpackage

// ===== verilog/rmc_remote_motor_command_map.sv
// How it works
// - each data item is 32 bits, seen as two 16-bit registers.
// - even address holds upper half, following odd address holds lower half.
// - operation command registers are volatile only, never saved.
// - group address pair at 0x30/0x31 is readable and writable.
// - remote input command pair at 0x7C/0x7D is readable and writable.
// - remote output status pair at 0x7E/0x7F is read only.
// - lower input register holds the sixteen remote terminals, default map.
// - three-wire mode reads bits 3,4,5 as gate, quick halt, direction.
// - any function can be assigned to any remote terminal or none.
// - two-wire: forward_run 1 turns forward, 0 stops.
// - two-wire: backward_run 1 turns reverse, 0 stops.
// - two-wire: halt_style_select 0 instant stop, 1 deceleration stop.
// - three-wire: runs only while motion_gate and quick_halt_gate are 1.
// - three-wire: gate 0 decelerates, quick halt 0 stops instantly.
// - three-wire: direction_select 0 forward, 1 reverse.
// - brake_release_on_stop 0 holds brake at stop, 1 releases it.
// - hold_release 1 frees a held stopped shaft when holding is enabled.
// - panel_unlock 0 limits setup tool functions, 1 lifts the limit.
// - operation data number 0..7 from op_select_bit2..0.
// - function on several terminals acts when any of them is active.
// - unassigned panel_unlock counts as constantly 1.
// - panel_unlock on remote and direct terminals needs both at 1.
module rmc_remote_motor_command_map
   import rmc_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire rmc_reg_req_t     reg_req,
   output rmc_reg_rsp_t          reg_rsp,
   input  wire logic [15:0][3:0] remote_fn_sel,
   input  wire logic [5:0][3:0]  direct_fn_sel,
   input  wire logic [5:0]       direct_in,
   input  wire logic             three_wire_mode,
   input  wire logic             load_hold_en,
   input  wire logic [31:0]      driver_status,
   output logic [31:0]           group_address,
   output rmc_motor_cmd_t        motor_cmd
);

   // ***********************************************************
   // volatile command registers
   // ***********************************************************
   logic [15:0]    group_hi_q;
   logic [15:0]    group_hi_d;
   logic [15:0]    group_lo_q;
   logic [15:0]    group_lo_d;
   logic [15:0]    remote_in_q;
   logic [15:0]    remote_in_d;
   rmc_reg_rsp_t   rsp_d;
   logic           ack_q;
   logic           err_q;
   logic [15:0]    rdata_q;
   rmc_motor_cmd_t cmd_q;
   rmc_motor_cmd_t cmd_d;
   logic [5:0]     direct_meta_q;
   logic [5:0]     direct_sync_q;

   // ***********************************************************
   // register number match
   // ***********************************************************
   // one map address against the number on the request
   function automatic logic addr_is(input logic [15:0] num,
                                    input logic [15:0] map_addr);
      return num == map_addr;
   endfunction

   // ***********************************************************
   // address decode
   // ***********************************************************
   logic        hit_grp_hi;
   logic        hit_grp_lo;
   logic        hit_in_hi;
   logic        hit_in_lo;
   logic        hit_out_hi;
   logic        hit_out_lo;

   logic        hit_any;
   logic        hit_ro;

   logic        wr_ok;
   logic        rd_ok;
   logic [15:0] rd_mux;

   assign hit_grp_hi = addr_is(reg_req.addr, ADDR_GROUP_HIGH);
   assign hit_grp_lo = addr_is(reg_req.addr, ADDR_GROUP_LOW);
   assign hit_in_hi  = addr_is(reg_req.addr, ADDR_REMOTE_INPUT_HIGH);
   assign hit_in_lo  = addr_is(reg_req.addr, ADDR_REMOTE_INPUT_LOW);
   assign hit_out_hi = addr_is(reg_req.addr, ADDR_REMOTE_OUTPUT_HIGH);
   assign hit_out_lo = addr_is(reg_req.addr, ADDR_REMOTE_OUTPUT_LOW);

   assign hit_ro     = hit_out_hi | hit_out_lo;
   assign hit_any    = hit_grp_hi | hit_grp_lo | hit_in_hi | hit_in_lo |
                       hit_ro;

   // ***********************************************************
   // access errors
   // ***********************************************************
   logic err_unmapped;
   logic err_ro_wr;
   logic acc_err;

   assign err_unmapped = ~hit_any;
   // the status pair takes reads only
   assign err_ro_wr    = reg_req.wr & hit_ro;
   assign acc_err      = err_unmapped | err_ro_wr;

   // ***********************************************************
   // access qualify
   // ***********************************************************
   assign wr_ok = reg_req.stb & reg_req.wr & ~acc_err;
   assign rd_ok = reg_req.stb & ~reg_req.wr & ~acc_err;

   // ***********************************************************
   // write enables
   // ***********************************************************
   logic we_grp_hi;
   logic we_grp_lo;
   logic we_in_lo;

   assign we_grp_hi = wr_ok & hit_grp_hi;
   assign we_grp_lo = wr_ok & hit_grp_lo;
   // upper input word has no terminals: write taken and dropped
   assign we_in_lo  = wr_ok & hit_in_lo;

   // ***********************************************************
   // register writes
   // ***********************************************************
   // each half lands on its own; a lone half leaves the item mixed
   assign group_hi_d  = we_grp_hi ? reg_req.wdata : group_hi_q;

   assign group_lo_d  = we_grp_lo ? reg_req.wdata : group_lo_q;

   assign remote_in_d = we_in_lo ? reg_req.wdata : remote_in_q;

   // ***********************************************************
   // register reads
   // ***********************************************************
   assign rd_mux = hit_grp_hi ? group_hi_q :
                   hit_grp_lo ? group_lo_q :
                   hit_in_hi  ? RESERVED_READ :
                   hit_in_lo  ? remote_in_q :
                   hit_out_hi ? driver_status[31:16] :
                   hit_out_lo ? driver_status[15:0] :
                   RESERVED_READ;

   // ***********************************************************
   // response
   // ***********************************************************
   assign rsp_d.ack   = reg_req.stb;
   assign rsp_d.err   = reg_req.stb & acc_err;
   assign rsp_d.rdata = rd_ok ? rd_mux : 16'h0000;

   // ***********************************************************
   // direct input synchroniser
   // ***********************************************************
   // first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         direct_meta_q <= 6'h00;
      end else begin
         direct_meta_q <= direct_in;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         direct_sync_q <= 6'h00;
      end else begin
         direct_sync_q <= direct_meta_q;
      end
   end

   // ***********************************************************
   // terminal function scan
   // ***********************************************************
   logic [15:0][3:0]    direct_sel_pad;
   logic [15:0]         direct_val_pad;

   logic [FN_COUNT-1:0] rem_asg;
   logic [FN_COUNT-1:0] rem_act;
   logic [FN_COUNT-1:0] dir_asg;
   logic [FN_COUNT-1:0] dir_act;

   logic [FN_COUNT-1:0] fn_on;

   assign direct_sel_pad = {{10{FN_UNUSED}}, direct_fn_sel};
   assign direct_val_pad = {10'h000, direct_sync_q};

   for (genvar f = 1; f < FN_COUNT; f++) begin : g_rem
      // any terminal position may carry any function
      assign {rem_asg[f], rem_act[f]} =
         rmc_scan(4'(f), remote_fn_sel, remote_in_q);
   end

   for (genvar f = 1; f < FN_COUNT; f++) begin : g_dir
      assign {dir_asg[f], dir_act[f]} =
         rmc_scan(4'(f), direct_sel_pad, direct_val_pad);
   end

   for (genvar f = 1; f < FN_COUNT; f++) begin : g_fn
      assign fn_on[f] = rem_act[f] | dir_act[f];
   end

   assign rem_asg[0] = 1'b0;
   assign rem_act[0] = 1'b0;
   assign dir_asg[0] = 1'b0;
   assign dir_act[0] = 1'b0;
   assign fn_on[0]   = 1'b0;

   // ***********************************************************
   // function view
   // ***********************************************************
   logic       fwd_gate;
   logic       rev_qhalt;
   logic       style_dir;
   logic       brake_free;
   logic       hold_free;
   logic [2:0] op_bits;

   assign fwd_gate   = fn_on[FN_FWD_GATE];
   assign rev_qhalt  = fn_on[FN_REV_QHALT];
   assign style_dir  = fn_on[FN_STYLE_DIR];
   assign brake_free = fn_on[FN_BRAKE_FREE];
   assign hold_free  = fn_on[FN_HOLD_FREE];
   assign op_bits    = {fn_on[FN_OP2], fn_on[FN_OP1],
                        fn_on[FN_OP0]};

   // ***********************************************************
   // two-wire decode
   // ***********************************************************
   logic run2;
   logic rev2;
   logic decel2;

   // one direction bit alone runs; both or none stop
   assign run2   = fwd_gate ^ rev_qhalt;
   assign rev2   = rev_qhalt & ~fwd_gate;
   assign decel2 = style_dir;

   // ***********************************************************
   // three-wire decode
   // ***********************************************************
   logic run3;
   logic rev3;
   logic decel3;

   // same positions read as gate, quick halt and direction
   assign run3   = fwd_gate & rev_qhalt;
   assign rev3   = style_dir;
   // quick halt low wins: instant; else gate low decelerates
   assign decel3 = rev_qhalt;

   // ***********************************************************
   // mode select
   // ***********************************************************
   logic run_now;
   logic rev_now;
   logic decel_now;

   assign run_now   = three_wire_mode ? run3 : run2;
   assign rev_now   = three_wire_mode ? rev3 : rev2;
   assign decel_now = three_wire_mode ? decel3 : decel2;

   // ***********************************************************
   // panel unlock
   // ***********************************************************
   logic panel_both;
   logic panel_now;

   // missing counts as 1, on both sides needs both
   assign panel_both = rem_asg[FN_PANEL] & dir_asg[FN_PANEL];
   assign panel_now =
      panel_both        ? (rem_act[FN_PANEL] & dir_act[FN_PANEL]) :
      rem_asg[FN_PANEL] ? rem_act[FN_PANEL] :
      dir_asg[FN_PANEL] ? dir_act[FN_PANEL] : 1'b1;

   // ***********************************************************
   // command assembly
   // ***********************************************************
   assign cmd_d.run           = run_now;
   assign cmd_d.reverse       = rev_now;
   assign cmd_d.decel_stop    = decel_now;
   // stop outputs only act with the motor at rest
   assign cmd_d.brake_release = brake_free & ~run_now;
   assign cmd_d.shaft_free    = hold_free & load_hold_en &
                                ~run_now;
   assign cmd_d.panel_unlock  = panel_now;
   assign cmd_d.op_data_no    = op_bits;

   // ***********************************************************
   // group address registers, flip-flops only
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         group_hi_q <= GROUP_RST[31:16];
      end else begin
         group_hi_q <= group_hi_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         group_lo_q <= GROUP_RST[15:0];
      end else begin
         group_lo_q <= group_lo_d;
      end
   end

   // ***********************************************************
   // remote input register, flip-flops only
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         remote_in_q <= REMOTE_INPUT_RST;
      end else begin
         remote_in_q <= remote_in_d;
      end
   end

   // ***********************************************************
   // response registers
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= rsp_d.ack;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         err_q <= 1'b0;
      end else begin
         err_q <= rsp_d.err;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rsp_d.rdata;
      end
   end

   // ***********************************************************
   // command register
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_q <= '0;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign reg_rsp.ack   = ack_q;
   assign reg_rsp.err   = err_q;
   assign reg_rsp.rdata = rdata_q;
   assign group_address = {group_hi_q, group_lo_q};
   assign motor_cmd     = cmd_q;

endmodule
